// [bench/pin_glass_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pin_glass_model (
  // clock
  input wire logic clock,
  // requested pin levels, plane freeze
  input wire logic [14:0] level,
  input wire logic hold,
  // towards the block
  output var logic [7:0] pin_in_h,
  output var logic [6:0] pin_in_j,
  output var logic [39:0] front_plane_output
);
  // start values
  initial begin
    {pin_in_j, pin_in_h} = 15'h0000;
    front_plane_output = 40'h00F0C35A96;
  end
  // pins follow the request one edge late, planes move unless frozen
  always @(posedge clock) begin
    {pin_in_j, pin_in_h} <= level;
    if (!hold) begin
      front_plane_output <= {front_plane_output[38:0], ~front_plane_output[39]};
    end
  end
endmodule // pin_glass_model
`default_nettype wire

// [bench/port_h_j_alt_function_override_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pin_mux_hj_cfg.svh"
module port_h_j_alt_function_override_tb;
  // stimulus and observed signals
  logic clock = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, hold = 1'b0;
  logic clock_enable = 1'b1, waitrequest, irq;
  logic [3:0] byteenable = 4'hF;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [14:0] level = 15'h0000;
  wire logic [14:0] src_s, ana_s;
  logic [7:0] pin_in_h, pin_change_source_h, analog_pin_connection_h;
  logic [6:0] pin_in_j, pin_change_source_j, analog_pin_connection_j;
  logic [39:0] front_plane_output, fp;
  pin_mux_hj_pkg::override_t overrides, ovr_s;
  int bad_count = 0, n_tests = 0, cyc = 0;
  logic [7:0] seg_h;
  logic [6:0] seg_j;
  assign fp = front_plane_output;
  // plane expected on each pin, msb first
  assign seg_h = {fp[36], fp[37], fp[38], fp[39], fp[7], fp[8], fp[9], fp[10]};
  assign seg_j = {fp[27], fp[28], fp[29], fp[30], fp[31], fp[34], fp[35]};
  always #20 clock = ~clock;
  // full variant, small variant and far side
  port_hj_override i_dut (.clock, .rst_n, .clock_enable, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .irq, .pin_in_h, .pin_in_j, .front_plane_output,
    .overrides, .pin_change_source_h, .pin_change_source_j, .analog_pin_connection_h,
    .analog_pin_connection_j);
  port_hj_override #(.HAS_PORTS_HJ(1'b0)) i_small (.clock, .rst_n, .clock_enable, .address,
    .read, .write, .writedata, .byteenable, .readdata(), .waitrequest(), .irq(), .pin_in_h,
    .pin_in_j, .front_plane_output, .overrides(ovr_s), .pin_change_source_h(src_s[7:0]),
    .pin_change_source_j(src_s[14:8]), .analog_pin_connection_h(ana_s[7:0]),
    .analog_pin_connection_j(ana_s[14:8]));
  pin_glass_model i_glass (.clock, .level, .hold, .pin_in_h, .pin_in_j, .front_plane_output);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon access, raised after a rising edge, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_IRQ_STATUS, 32'h0);
    rd(5'h1C, 32'h0);
    chk({17'h0, overrides.pullup_override_enable}, 32'h0);
  endtask
  task automatic t_lcd_irq();
    hold <= 1'b1;
    bus(1'b1, `OFS_CTRL, 32'h1);
    repeat (2) @(negedge clock);
    chk({17'h0, overrides.pullup_override_enable}, 32'h7FFF);
    chk({17'h0, overrides.direction_override_enable}, 32'h7FFF);
    chk({17'h0, overrides.port_value_override_enable}, 32'h0);
    chk({24'h0, analog_pin_connection_h}, {24'h0, seg_h});
    chk({25'h0, analog_pin_connection_j}, {25'h0, seg_j});
    chk({2'h0, ovr_s.pullup_override_enable, ana_s}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    repeat (2) @(negedge clock);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, `OFS_IRQ_STATUS, 32'hF);
    rd(`OFS_IRQ_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    hold <= 1'b0;
  endtask
  task automatic t_die();
    bus(1'b1, `OFS_MASK_H, 32'hFF);
    bus(1'b1, `OFS_MASK_J, 32'h7F);
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, `OFS_CTRL, k);
      repeat (2) @(negedge clock);
      chk({17'h0, overrides.input_enable_override_enable}, (k == 7) ? 32'h7FFF : 32'h0);
      chk({17'h0, overrides.pullup_override_enable}, k[0] ? 32'h7FFF : 32'h0);
    end
    bus(1'b1, `OFS_MASK_H, 32'h81);
    bus(1'b1, `OFS_MASK_J, 32'h40);
    rd(`OFS_DIE_STATE, 32'h4081);
  endtask
  task automatic t_pins();
    bus(1'b1, `OFS_CTRL, 32'h0);
    for (int i = 0; i < 15; i++) begin
      @(posedge clock);
      level <= 15'h0001 << i;
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk({17'h0, pin_change_source_j, pin_change_source_h}, 32'h1 << i);
    end
    rd(`OFS_PIN_STATE, 32'h4000);
    chk({17'h0, analog_pin_connection_j, analog_pin_connection_h}, 32'h0);
  endtask
  // pin change events, lane 0 gating, clock enable freeze
  task automatic t_events();
    bus(1'b1, `OFS_MASK_H, 32'h01);
    bus(1'b1, `OFS_MASK_J, 32'h02);
    bus(1'b1, `OFS_IRQ_MASK, 32'hC);
    bus(1'b1, `OFS_CTRL, 32'h4);
    bus(1'b1, `OFS_IRQ_STATUS, 32'hF);
    rd(`OFS_IRQ_STATUS, 32'h0);
    level <= 15'h0001;
    repeat (3) @(posedge clock);
    rd(`OFS_IRQ_STATUS, 32'h4);
    chk({31'h0, irq}, 32'h1);
    level <= 15'h0201;
    repeat (3) @(posedge clock);
    rd(`OFS_IRQ_STATUS, 32'hC);
    byteenable <= 4'h0;
    bus(1'b1, `OFS_IRQ_STATUS, 32'hF);
    byteenable <= 4'hF;
    rd(`OFS_IRQ_STATUS, 32'hC);
    bus(1'b1, `OFS_IRQ_STATUS, 32'hF);
    rd(`OFS_IRQ_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    clock_enable <= 1'b0;
    level <= 15'h0000;
    repeat (4) @(negedge clock);
    chk({17'h0, pin_change_source_j, pin_change_source_h}, 32'h0201);
    @(posedge clock);
    clock_enable <= 1'b1;
    repeat (2) @(negedge clock);
    chk({17'h0, pin_change_source_j, pin_change_source_h}, 32'h0);
    rd(`OFS_IRQ_STATUS, 32'hC);
  endtask
  // ----------------------------------------
  // run and verdict
  // ----------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_lcd_irq();
    t_die();
    t_pins();
    t_events();
    final_report();
  end
endmodule // port_h_j_alt_function_override_tb
`default_nettype wire

// [bench/port_hj_override_props.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// override checker
// ----------------------------------------
module port_hj_override_props #(
  parameter bit HAS_PORTS_HJ = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_enable,
  // pins and planes
  input wire logic [7:0] pin_in_h,
  input wire logic [6:0] pin_in_j,
  input wire logic [39:0] front_plane_output,
  // block outputs
  input wire pin_mux_hj_pkg::override_t overrides,
  input wire logic [7:0] pin_change_source_h,
  input wire logic [6:0] pin_change_source_j,
  input wire logic [7:0] analog_pin_connection_h,
  input wire logic [6:0] analog_pin_connection_j
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // lcd state seen on the pull-up lanes, plane order per pin
  wire logic lcd_on = overrides.pullup_override_enable[0];
  wire logic [39:0] fp = front_plane_output;
  wire logic [7:0] map_h = {fp[36], fp[37], fp[38], fp[39], fp[7], fp[8], fp[9], fp[10]};
  wire logic [6:0] map_j = {fp[27], fp[28], fp[29], fp[30], fp[31], fp[34], fp[35]};
  sequence en_edge;
    clock_enable && HAS_PORTS_HJ;
  endsequence
  sequence lcd_held;
    $past(clock_enable) && lcd_on;
  endsequence
  pu_force_a: assert property (overrides.pullup_override_value == 15'h0000 &&
    overrides.pullup_override_enable inside {15'h0000, 15'h7FFF}) else $error("pull-up");
  dir_in_a: assert property (overrides.direction_override_value == 15'h0000 &&
    overrides.direction_override_enable == overrides.pullup_override_enable) else $error("dir");
  pv_zero_a: assert property ((overrides.port_value_override_enable |
    overrides.port_value_override_value) == 15'h0000) else $error("port value");
  die_need_a: assert property (overrides.input_enable_override_enable != 15'h0000
    |-> lcd_on && overrides.input_enable_override_value ==
    overrides.input_enable_override_enable) else $error("input enable");
  src_h_a: assert property (en_edge |=> pin_change_source_h == $past(pin_in_h))
    else $error("source h");
  src_j_a: assert property (en_edge |=> pin_change_source_j == $past(pin_in_j))
    else $error("source j");
  seg_h_a: assert property (lcd_held |-> analog_pin_connection_h == $past(map_h))
    else $error("segment h");
  seg_j_a: assert property (lcd_held |-> analog_pin_connection_j == $past(map_j))
    else $error("segment j");
  lcd_off_a: assert property (!lcd_on |-> {analog_pin_connection_j,
    analog_pin_connection_h} == 15'h0000) else $error("segment off");
  small_zero_a: assert property (!HAS_PORTS_HJ |-> overrides == '0 &&
    {pin_change_source_j, pin_change_source_h} == 15'h0000) else $error("variant");
endmodule // port_hj_override_props
bind port_hj_override port_hj_override_props #(.HAS_PORTS_HJ(HAS_PORTS_HJ)) i_props (
  .clock, .rst_n, .clock_enable, .pin_in_h, .pin_in_j, .front_plane_output, .overrides,
  .pin_change_source_h, .pin_change_source_j, .analog_pin_connection_h,
  .analog_pin_connection_j);
`default_nettype wire

// [hw/pin_mux_hj_cfg.svh]
// What this block does
// [RULE1] lcd on: pull-up override forced off
// [RULE2] lcd on: direction override to input
// [RULE3] port value override never enabled
// [RULE4] input override needs mask, group, lcd, low-power
// [RULE5] port h bits feed sources 23..16
// [RULE6] port j bits feed sources 30..24
// [RULE7] port h drives planes 36-39, 7-10
// [RULE8] port j drives planes 27-31, 34, 35
// [RULE9] h input to pin change, pin to segment
// [RULE10] small variants omit both ports entirely; the code zeroes their outputs but still reads the pins back at OFS_PIN_STATE
// [RULE11] lcd off: pull-up, direction overrides inactive
`ifndef PIN_MUX_HJ_CFG_SVH
`define PIN_MUX_HJ_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 5'h00
`define OFS_MASK_H 5'h04
`define OFS_MASK_J 5'h08
`define OFS_DIE_STATE 5'h0C
`define OFS_PIN_STATE 5'h10
`define OFS_IRQ_STATUS 5'h14
`define OFS_IRQ_MASK 5'h18
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define EV_LCD_ON 0
`define EV_LCD_OFF 1
`define EV_CHANGE_H 2
`define EV_CHANGE_J 3
`define RST_CTRL 3'h0
`define RST_MASK_H 8'h00
`define RST_MASK_J 7'h00
`define RST_IRQ 4'h0
// ----------------------------------------
// front plane numbers per pin
// ----------------------------------------
`define FP_H7 36
`define FP_H6 37
`define FP_H5 38
`define FP_H4 39
`define FP_H3 7
`define FP_H2 8
`define FP_H1 9
`define FP_H0 10
`define FP_J6 27
`define FP_J5 28
`define FP_J4 29
`define FP_J3 30
`define FP_J2 31
`define FP_J1 34
`define FP_J0 35
`endif

// [hw/pin_mux_hj_pkg.sv]
package pin_mux_hj_pkg;
  // control bits of the block
  typedef struct packed {
    logic pin_change_group_enable;
    logic lcd_low_power_setting;
    logic lcd_enable;
  } ctrl_t;
  // per-pin override lanes, bits 14:8 port j, 7:0 port h
  typedef struct packed {
    logic [14:0] pullup_override_enable;
    logic [14:0] pullup_override_value;
    logic [14:0] direction_override_enable;
    logic [14:0] direction_override_value;
    logic [14:0] port_value_override_enable;
    logic [14:0] port_value_override_value;
    logic [14:0] input_enable_override_enable;
    logic [14:0] input_enable_override_value;
  } override_t;
  // bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK = 2'h2
  } bus_state_t;
endpackage

// [hw/port_hj_override.sv]
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "pin_mux_hj_cfg.svh"
module port_hj_override #(
  parameter bit HAS_PORTS_HJ = 1'b1
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_enable,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // interrupt
  output logic irq,
  // pin side digital inputs
  input wire logic [7:0] pin_in_h,
  input wire logic [6:0] pin_in_j,
  // lcd controller front planes
  input wire logic [39:0] front_plane_output,
  // overrides towards the port logic
  output pin_mux_hj_pkg::override_t overrides,
  // pin change sources
  output logic [7:0] pin_change_source_h,
  output logic [6:0] pin_change_source_j,
  // segment drive onto the pins
  output logic [7:0] analog_pin_connection_h,
  output logic [6:0] analog_pin_connection_j
);

  // ----------------------------------------
  // front plane lookup
  // ----------------------------------------
  localparam int FP_H [8] = '{`FP_H0, `FP_H1, `FP_H2, `FP_H3,
                              `FP_H4, `FP_H5, `FP_H6, `FP_H7}; // [RULE7]
  localparam int FP_J [7] = '{`FP_J0, `FP_J1, `FP_J2, `FP_J3,
                              `FP_J4, `FP_J5, `FP_J6}; // [RULE8]

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  pin_mux_hj_pkg::bus_state_t bus_state;
  pin_mux_hj_pkg::ctrl_t ctrl;
  pin_mux_hj_pkg::override_t next_overrides;
  logic [7:0] mask_h;
  logic [6:0] mask_j;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [3:0] irq_set;
  logic [3:0] irq_clr;
  logic [7:0] pin_q_h;
  logic [6:0] pin_q_j;
  logic lcd_q;
  logic bus_req;
  logic bus_fire;
  logic wr_fire;
  logic lane0;
  logic [31:0] next_readdata;
  logic [14:0] pin_mask;
  logic [14:0] die_en;
  logic [7:0] next_seg_h;
  logic [6:0] next_seg_j;

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------

  // one wait cycle per access
  assign bus_req = read | write;
  assign bus_fire = (bus_state == pin_mux_hj_pkg::BUS_ACK) & clock_enable;
  assign waitrequest = bus_req & ~bus_fire;
  assign wr_fire = write & bus_fire;
  assign lane0 = byteenable[0];

  // handshake state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= pin_mux_hj_pkg::BUS_IDLE;
    end else if (clock_enable) begin
      case (bus_state)
        pin_mux_hj_pkg::BUS_IDLE: begin
          if (bus_req) begin
            bus_state <= pin_mux_hj_pkg::BUS_ACK;
          end
        end
        pin_mux_hj_pkg::BUS_ACK: begin
          bus_state <= pin_mux_hj_pkg::BUS_IDLE;
        end
        default: begin
          bus_state <= pin_mux_hj_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // read mux, unmapped reads give zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (address)
      `OFS_CTRL: next_readdata[2:0] = ctrl;
      `OFS_MASK_H: next_readdata[7:0] = mask_h;
      `OFS_MASK_J: next_readdata[6:0] = mask_j;
      `OFS_DIE_STATE: next_readdata[14:0] = overrides.input_enable_override_enable;
      `OFS_PIN_STATE: next_readdata[14:0] = {pin_q_j, pin_q_h};
      `OFS_IRQ_STATUS: next_readdata[3:0] = irq_status;
      `OFS_IRQ_MASK: next_readdata[3:0] = irq_mask;
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // read data caught in the wait cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (clock_enable) begin
      if (read && bus_state == pin_mux_hj_pkg::BUS_IDLE) begin
        readdata <= next_readdata;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------

  // control bits, written on lane 0 only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `RST_CTRL;
    end else if (wr_fire && lane0 && address == `OFS_CTRL) begin
      ctrl <= writedata[2:0];
    end
  end

  // pin change masks per port
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask_h <= `RST_MASK_H;
      mask_j <= `RST_MASK_J;
    end else if (wr_fire && lane0) begin
      case (address)
        `OFS_MASK_H: mask_h <= writedata[7:0];
        `OFS_MASK_J: mask_j <= writedata[6:0];
        default: mask_h <= mask_h;
      endcase
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= `RST_IRQ;
    end else if (wr_fire && lane0 && address == `OFS_IRQ_MASK) begin
      irq_mask <= writedata[3:0];
    end
  end

  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------

  // pin input history for change detection
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_q_h <= 8'h00;
      pin_q_j <= 7'h00;
    end else if (clock_enable) begin
      pin_q_h <= pin_in_h;
      pin_q_j <= pin_in_j;
    end
  end

  // lcd enable history for on and off events
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lcd_q <= 1'b0;
    end else if (clock_enable) begin
      lcd_q <= ctrl.lcd_enable;
    end
  end

  // event sources; masked changes only while group enabled
  always_comb begin
    irq_set = 4'h0;
    irq_set[`EV_LCD_ON] = ctrl.lcd_enable & ~lcd_q;
    irq_set[`EV_LCD_OFF] = ~ctrl.lcd_enable & lcd_q;
    irq_set[`EV_CHANGE_H] = ctrl.pin_change_group_enable
                            & |((pin_q_h ^ pin_in_h) & mask_h);
    irq_set[`EV_CHANGE_J] = ctrl.pin_change_group_enable
                            & |((pin_q_j ^ pin_in_j) & mask_j);
    if (!HAS_PORTS_HJ) begin
      irq_set = 4'h0;
    end
  end

  // write one to clear
  assign irq_clr = (wr_fire && lane0 && address == `OFS_IRQ_STATUS)
                   ? writedata[3:0] : 4'h0;

  // sticky status, set beats clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= `RST_IRQ;
    end else if (clock_enable) begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  // level interrupt output
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (clock_enable) begin
      irq <= |((((irq_status & ~irq_clr) | irq_set)) & irq_mask);
    end
  end

  // ----------------------------------------
  // override generation
  // ----------------------------------------

  // input enable override needs all four conditions
  assign pin_mask = {mask_j, mask_h};
  assign die_en = pin_mask & {15{ctrl.pin_change_group_enable & ctrl.lcd_enable
                                 & ctrl.lcd_low_power_setting}}; // [RULE4]

  // per-pin override values
  always_comb begin
    next_overrides = '0;
    next_overrides.pullup_override_enable = {15{ctrl.lcd_enable}}; // [RULE1] [RULE11]
    next_overrides.pullup_override_value = 15'h0000; // [RULE1]
    next_overrides.direction_override_enable = {15{ctrl.lcd_enable}}; // [RULE2] [RULE11]
    next_overrides.direction_override_value = 15'h0000; // [RULE2]
    next_overrides.port_value_override_enable = 15'h0000; // [RULE3]
    next_overrides.port_value_override_value = 15'h0000;
    next_overrides.input_enable_override_enable = die_en;
    next_overrides.input_enable_override_value = die_en;
    if (!HAS_PORTS_HJ) begin
      next_overrides = '0; // [RULE10]
    end
  end

  // registered overrides
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overrides <= '0;
    end else if (clock_enable) begin
      overrides <= next_overrides;
    end
  end

  // ----------------------------------------
  // pin change and segment routing
  // ----------------------------------------

  // front plane selection per pin
  always_comb begin
    next_seg_h = 8'h00;
    next_seg_j = 7'h00;
    for (int i = 0; i < 8; i++) begin
      next_seg_h[i] = front_plane_output[FP_H[i]]; // [RULE7] [RULE9]
    end
    for (int i = 0; i < 7; i++) begin
      next_seg_j[i] = front_plane_output[FP_J[i]]; // [RULE8]
    end
  end

  // digital inputs to the pin change sources, one edge late
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_change_source_h <= 8'h00;
      pin_change_source_j <= 7'h00;
    end else if (clock_enable) begin
      if (HAS_PORTS_HJ) begin
        pin_change_source_h <= pin_in_h; // [RULE5] [RULE9]
        pin_change_source_j <= pin_in_j; // [RULE6]
      end else begin
        pin_change_source_h <= 8'h00; // [RULE10]
        pin_change_source_j <= 7'h00;
      end
    end
  end

  // segment drive onto the pins, low while the lcd is off
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      analog_pin_connection_h <= 8'h00;
      analog_pin_connection_j <= 7'h00;
    end else if (clock_enable) begin
      if (HAS_PORTS_HJ && ctrl.lcd_enable) begin
        analog_pin_connection_h <= next_seg_h; // [RULE9]
        analog_pin_connection_j <= next_seg_j;
      end else begin
        analog_pin_connection_h <= 8'h00; // [RULE10] [RULE11]
        analog_pin_connection_j <= 7'h00;
      end
    end
  end

endmodule // port_hj_override
`default_nettype wire
